// ### rtl/itp_counter.sv
// itp_counter: one 16-bit down counter with six modes and host byte access
// assumes clk_en_in is a one-cycle count pulse and bus strobes last one cycle
`timescale 1ns/1ps
module itp_counter
   import itp_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rstn_in,
   // counting inputs
   input  wire logic        clk_en_in,
   input  wire logic        gate_in,
   // host access
   input  wire logic        ctrl_wr_in,
   input  wire itp_pkg::itp_cfg_type cfg_in,
   input  wire logic        latch_cnt_in,
   input  wire logic        latch_sta_in,
   input  wire logic        data_wr_in,
   input  wire logic        data_rd_in,
   input  wire logic [7:0]  wdata_in,
   // outputs
   output logic [7:0]       rdata_out,
   output logic             out_out
);
   typedef enum logic [1:0] {
      ITP_IDLE = 2'b00,
      ITP_RUN  = 2'b01,
      ITP_WAIT = 2'b10
   } itp_st_type;
   itp_cfg_type cfg_r, cfg_nxt;
   itp_st_type  st_r, st_nxt;
   logic [15:0] cnt_r, cnt_nxt, init_r, init_nxt, hold_r, hold_nxt;
   logic [7:0]  lo_r, lo_nxt, sta_r, sta_nxt, rdata_nxt;
   logic        out_nxt, wptr_r, wptr_nxt, rptr_r, rptr_nxt;
   logic        held_r, held_nxt, stv_r, stv_nxt, null_r, null_nxt;
   logic        gate_q_r, trig_r, trig_nxt, load_r, load_nxt;
   logic        gate_rise, is_bcd, tc, m3, new_load;
   logic [15:0] n_eff, dec1, dec2;
   // decrement by one or two in binary or BCD [R10]
   function automatic logic [15:0] dec_by(input logic [15:0] v, input logic bcd,
                                          input logic [1:0] k);
      logic [15:0] r;
      r = v;
      for (int i = 0; i < 2; i++) begin
         if (i < k) begin
            if (!bcd) begin
               r = r - 16'h0001;
            end else if (r[3:0] != 4'h0) begin
               r = r - 16'h0001;
            end else if (r[7:4] != 4'h0) begin
               r = {r[15:8], r[7:4] - 4'h1, 4'h9};
            end else if (r[11:8] != 4'h0) begin
               r = {r[15:12], r[11:8] - 4'h1, 8'h99};
            end else if (r[15:12] != 4'h0) begin
               r = {r[15:12] - 4'h1, 12'h999};
            end else begin
               r = 16'h9999;
            end
         end
      end
      return r;
   endfunction
   assign gate_rise = gate_in && !gate_q_r;
   assign is_bcd    = cfg_r.bcd;
   assign m3        = (cfg_r.op_mode[1:0] == 2'b11);
   assign dec1      = dec_by(cnt_r, is_bcd, 2'd1);
   assign dec2      = dec_by(cnt_r, is_bcd, 2'd2);
   assign n_eff     = (m3 && !out_out) ? {init_r[15:1], 1'b0} : init_r;
   assign tc        = (cnt_r == 16'h0001) || (m3 && cnt_r == 16'h0002);
   // byte that completes a count; a load pending at the same tick must not eat it
   assign new_load  = data_wr_in && (cfg_r.access_kind != ITP_ACC_LOHI || wptr_r);
   // control, data and count next state
   always_comb begin
      cfg_nxt = cfg_r; st_nxt = st_r; cnt_nxt = cnt_r; init_nxt = init_r;
      hold_nxt = hold_r; lo_nxt = lo_r; sta_nxt = sta_r; out_nxt = out_out;
      wptr_nxt = wptr_r; rptr_nxt = rptr_r; held_nxt = held_r; stv_nxt = stv_r;
      null_nxt = null_r; trig_nxt = trig_r; load_nxt = load_r; rdata_nxt = rdata_out;
      if (gate_rise) begin
         trig_nxt = 1'b1;                                  // [R18] [R22]
      end
      if (ctrl_wr_in) begin
         cfg_nxt  = cfg_in;
         st_nxt   = ITP_IDLE;
         out_nxt  = (cfg_in.op_mode != 3'b000);            // [R16] [R21]
         wptr_nxt = 1'b0;                                  // [R23]
         rptr_nxt = 1'b0;
         held_nxt = 1'b0;
         stv_nxt  = 1'b0;
         null_nxt = 1'b1;
         trig_nxt = 1'b0;
      end
      if (latch_cnt_in && !held_r) begin
         hold_nxt = cnt_r;                                 // [R14]
         held_nxt = 1'b1;
      end
      if (latch_sta_in && !stv_r) begin
         sta_nxt = {out_out, null_r, cfg_r};               // [R12]
         stv_nxt = 1'b1;
      end
      if (data_wr_in) begin
         unique case (cfg_r.access_kind)
            ITP_ACC_LO_ONLY: begin
               init_nxt = {8'h00, wdata_in}; load_nxt = 1'b1; null_nxt = 1'b1;
            end
            ITP_ACC_HI_ONLY: begin
               init_nxt = {wdata_in, 8'h00}; load_nxt = 1'b1; null_nxt = 1'b1;
            end
            default: begin
               wptr_nxt = !wptr_r;                         // [R23]
               if (!wptr_r) begin
                  lo_nxt = wdata_in;
                  if (cfg_r.op_mode == 3'b000) begin
                     st_nxt = ITP_IDLE;                    // [R17]
                  end
               end else begin
                  init_nxt = {wdata_in, lo_r}; load_nxt = 1'b1; null_nxt = 1'b1;
               end
            end
         endcase
      end
      if (data_rd_in) begin
         if (stv_r) begin
            rdata_nxt = sta_r;                             // [R13]
            stv_nxt   = 1'b0;
         end else begin
            rdata_nxt = (cfg_r.access_kind == ITP_ACC_HI_ONLY ||
                         (cfg_r.access_kind == ITP_ACC_LOHI && rptr_r))
                        ? (held_r ? hold_r[15:8] : cnt_r[15:8])
                        : (held_r ? hold_r[7:0] : cnt_r[7:0]);
            if (cfg_r.access_kind == ITP_ACC_LOHI) begin
               rptr_nxt = !rptr_r;
               held_nxt = held_r && !rptr_r;
            end else begin
               held_nxt = 1'b0;
            end
         end
      end
      // counting element, one step per count pulse
      if (clk_en_in && !ctrl_wr_in) begin
         if (load_r && (st_r == ITP_IDLE || cfg_r.op_mode[1] || cfg_r.op_mode == 3'b100)
             && !(cfg_r.op_mode[1] && st_r == ITP_RUN && cnt_r != 16'h0001 && !tc)) begin
            cnt_nxt = init_r; load_nxt = new_load; null_nxt = new_load;
            st_nxt  = cfg_r.op_mode[0] && !cfg_r.op_mode[1] ? ITP_WAIT : ITP_RUN;
            if (cfg_r.op_mode == 3'b000) begin
               out_nxt = 1'b0;                             // [R16]
            end
            if (cfg_r.op_mode[1]) begin
               out_nxt = 1'b1;
            end
         end else if ((cfg_r.op_mode[0] && !cfg_r.op_mode[1]) && trig_r && st_r != ITP_IDLE) begin
            cnt_nxt = init_r; trig_nxt = gate_rise; st_nxt = ITP_RUN;  // [R18] [R22]
            null_nxt = 1'b0;
            out_nxt = cfg_r.op_mode[2];
         end else if (cfg_r.op_mode[1] && !gate_in) begin
            out_nxt = 1'b1;                                // [R19]
            trig_nxt = 1'b0;
         end else if (cfg_r.op_mode[1] && trig_r) begin
            cnt_nxt = n_eff; trig_nxt = gate_rise; out_nxt = 1'b1;  // [R19]
         end else if (st_r == ITP_RUN && (gate_in || cfg_r.op_mode == 3'b001 ||
                                         cfg_r.op_mode == 3'b101)) begin
            if (m3) begin
               if (tc) begin
                  out_nxt = !out_out;                      // [R20]
                  cnt_nxt = (!out_out) ? init_r : {init_r[15:1], 1'b0};
               end else begin
                  cnt_nxt = (cnt_r[0] && out_out) ? dec1 : dec2;  // [R20]
               end
            end else if (cfg_r.op_mode[1]) begin
               cnt_nxt = tc ? init_r : dec1;               // [R19]
               out_nxt = (cnt_r != 16'h0002);
            end else begin
               cnt_nxt = dec1;
               unique case (cfg_r.op_mode)
                  3'b000: out_nxt = out_out || tc;         // [R16]
                  3'b001: out_nxt = out_out || tc;         // [R18]
                  default: begin
                     out_nxt = !tc;                        // [R21] [R22]
                     if (!out_out) begin
                        st_nxt = ITP_WAIT;
                     end
                  end
               endcase
            end
         end else if (!out_out && cfg_r.op_mode[2]) begin
            out_nxt = 1'b1;
         end
      end
   end
   // register the counter state
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cfg_r <= ITP_CFG_RESET; st_r <= ITP_IDLE; cnt_r <= 16'h0000;
         init_r <= 16'h0000; hold_r <= 16'h0000; lo_r <= 8'h00; sta_r <= 8'h00;
         rdata_out <= 8'h00; out_out <= 1'b0; wptr_r <= 1'b0; rptr_r <= 1'b0;
         held_r <= 1'b0; stv_r <= 1'b0; null_r <= 1'b1; gate_q_r <= 1'b0;
         trig_r <= 1'b0; load_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt; st_r <= st_nxt; cnt_r <= cnt_nxt; init_r <= init_nxt;
         hold_r <= hold_nxt; lo_r <= lo_nxt; sta_r <= sta_nxt; rdata_out <= rdata_nxt;
         out_out <= out_nxt; wptr_r <= wptr_nxt; rptr_r <= rptr_nxt;
         held_r <= held_nxt; stv_r <= stv_nxt; null_r <= null_nxt;
         gate_q_r <= gate_in; trig_r <= trig_nxt; load_r <= load_nxt;
      end
   end
   // a latched count stays put while counting goes on
   property p_hold_stable;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      held_r && !data_rd_in && !ctrl_wr_in |=> (hold_r == $past(hold_r));
   endproperty
   a_hold_stable: assert property (p_hold_stable) else $error("hold changed"); // [R14]
   // a pending status byte is what the next read returns
   property p_sta_read;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      stv_r && data_rd_in && !ctrl_wr_in |=> (rdata_out == $past(sta_r)) && !stv_r;
   endproperty
   a_sta_read: assert property (p_sta_read) else $error("status not read"); // [R13]
   // mode 0 output is low right after the control word
   property p_m0_low;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      ctrl_wr_in && cfg_in.op_mode == 3'b000 |=> !out_out;
   endproperty
   a_m0_low: assert property (p_m0_low) else $error("mode 0 not low"); // [R16]
   // the byte pointer goes back to the low byte on a control word
   property p_ptr_clear;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      ctrl_wr_in |=> !wptr_r && !rptr_r;
   endproperty
   a_ptr_clear: assert property (p_ptr_clear) else $error("pointer kept"); // [R23]
endmodule

// ### rtl/itp_pkg.sv
// itp_pkg: constants and types for the three-counter interval timer and pacer
// assumes one system clock; counter clocks arrive as synchronous level inputs
// Functional notes
// [R1] three independent 16-bit counters, each with clock, gate and output
// [R2] a 10 MHz internal count clock is derived from the system clock
// [R3] counter 0 counts internal ticks or external clock edges by a source select
// [R4] counter 0 counts only while its gate is high; modes 1 and 5 use the gate as a trigger and keep counting while it is low
// [R5] counters 1 and 2 chain as a 32-bit pacer; counter 2 rise starts a conversion
// [R6] data ports at offsets 24, 26, 28 and control word at offset 30
// [R7] control bits 7:6 pick counter 0, 1, 2, or read-back
// [R8] control bits 5:4 pick latch, low only, high only, or low then high
// [R9] control bits 3:1 pick modes 0 to 5, bit 3 ignored for modes 2, 3
// [R10] control bit 0 picks binary or BCD counting
// [R11] read-back latches counts and/or status for each selected counter
// [R12] status byte holds output, null count, then access kind, mode, format
// [R13] latched status is returned by the next data port read
// [R14] count latch holds a snapshot for later reads without disturbing counting
// [R15] host writes the control word first and pairs its byte accesses
// [R16] mode 0 output low until terminal count, then high; counting continues
// [R17] mode 0 first byte of a new count halts, second byte restarts
// [R18] mode 1 retriggerable one-shot started by a gate rise
// [R19] mode 2 one-clock low pulse every N clocks, gate low forces high
// [R20] mode 3 square wave, odd counts high (N+1)/2 low (N-1)/2
// [R21] mode 4 single low strobe at terminal count after a software load
// [R22] mode 5 strobe at terminal count after a gate rise, retriggerable
// [R23] each counter keeps a byte pointer reset by its control word
package itp_pkg;
   localparam logic [7:0] ITP_OFS_CNT0 = 8'h18;
   localparam logic [7:0] ITP_OFS_CNT1 = 8'h1a;
   localparam logic [7:0] ITP_OFS_CNT2 = 8'h1c;
   localparam logic [7:0] ITP_OFS_CTRL = 8'h1e;
   localparam int ITP_SEL_HI   = 7;
   localparam int ITP_SEL_LO   = 6;
   localparam int ITP_ACC_HI   = 5;
   localparam int ITP_ACC_LO   = 4;
   localparam int ITP_MODE_HI  = 3;
   localparam int ITP_MODE_LO  = 1;
   localparam int ITP_BCD_BIT  = 0;
   localparam int ITP_RB_CNT_N = 5;
   localparam int ITP_RB_STA_N = 4;
   localparam int ITP_RB_PICK0 = 1;
   localparam logic [1:0] ITP_SEL_READBACK = 2'b11;
   localparam logic [1:0] ITP_ACC_LATCH = 2'b00;
   localparam logic [1:0] ITP_ACC_LO_ONLY = 2'b01;
   localparam logic [1:0] ITP_ACC_HI_ONLY = 2'b10;
   localparam logic [1:0] ITP_ACC_LOHI = 2'b11;
   localparam logic [5:0] ITP_CFG_RESET = 6'h00;
   localparam int ITP_SYS_HZ  = 40_000_000;
   localparam int ITP_TICK_HZ = 10_000_000;
   localparam int ITP_TICK_DIV = ITP_SYS_HZ / ITP_TICK_HZ;
   // one counter's programmed setup: access kind, mode, BCD
   typedef struct packed {
      logic [1:0] access_kind;
      logic [2:0] op_mode;
      logic       bcd;
   } itp_cfg_type;
   // register bus request from the host side
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } itp_req_type;
endpackage

// ### rtl/itp_top.sv
// itp_top: three-counter interval timer with pacer chain and byte register port
// assumes host strobes last one cycle and are synchronous to clk_sys_in
`timescale 1ns/1ps
module itp_top
   import itp_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rstn_in,
   // host register port
   input  wire itp_pkg::itp_req_type req_in,
   output logic [7:0]       rdata_out,
   // counter 0 pins
   input  wire logic        counter0_ext_clock,
   input  wire logic        counter0_gate_in,
   input  wire logic        counter0_src_ext_in,
   output logic             counter0_out,
   // pacer
   input  wire logic        pacer_gate_in,
   output logic             pacer_sync_out,
   output logic             adc_start_out,
   output logic             tick_10mhz_out
);
   import itp_pkg::*;
   logic [1:0] div_r, div_nxt;
   logic       ext_q_r, p2_q_r, p2_q_r_d;
   logic [2:0] en, gt, cwr, lcnt, lsta, dwr, drd, outs;
   logic [7:0] rd [3];
   logic [7:0] rdata_nxt;
   logic [1:0] rsel_r, rsel_nxt;
   logic       rsel_v_r, rsel_v_nxt;
   logic       is_ctrl, is_rb;
   // 10 MHz tick from the 40 MHz system clock
   always_comb begin
      div_nxt = (div_r == 2'(ITP_TICK_DIV - 1)) ? 2'b00 : div_r + 2'b01;  // [R2]
   end
   assign tick_10mhz_out = (div_r == 2'b00);
   assign is_ctrl = req_in.wr && req_in.addr == ITP_OFS_CTRL;                 // [R6]
   assign is_rb   = req_in.wdata[ITP_SEL_HI:ITP_SEL_LO] == ITP_SEL_READBACK;  // [R7]
   // counter clock enables and gates
   assign en[0] = counter0_src_ext_in ? (counter0_ext_clock && !ext_q_r)
                                       : tick_10mhz_out;                      // [R3]
   assign gt[0] = counter0_gate_in;                                           // [R4]
   assign en[1] = tick_10mhz_out;
   assign gt[1] = pacer_gate_in;
   assign en[2] = outs[1] && !p2_q_r;                                         // [R5]
   assign gt[2] = pacer_gate_in;
   // per-counter decode and instances [R1]
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_cnt
         localparam logic [7:0] OFS = ITP_OFS_CNT0 + 8'(2 * gi);
         assign cwr[gi]  = is_ctrl && !is_rb && req_in.wdata[7:6] == 2'(gi)
                           && req_in.wdata[5:4] != ITP_ACC_LATCH;             // [R8]
         assign lcnt[gi] = is_ctrl && ((!is_rb && req_in.wdata[7:6] == 2'(gi) &&
                           req_in.wdata[5:4] == ITP_ACC_LATCH) ||
                           (is_rb && !req_in.wdata[ITP_RB_CNT_N] &&
                            req_in.wdata[ITP_RB_PICK0 + gi]));                // [R11]
         assign lsta[gi] = is_ctrl && is_rb && !req_in.wdata[ITP_RB_STA_N] &&
                           req_in.wdata[ITP_RB_PICK0 + gi];                   // [R11]
         assign dwr[gi]  = req_in.wr && req_in.addr == OFS;                   // [R6]
         assign drd[gi]  = req_in.rd && req_in.addr == OFS;
         itp_counter u_cnt (
            .clk_sys_in   (clk_sys_in),
            .rstn_in      (rstn_in),
            .clk_en_in    (en[gi]),
            .gate_in      (gt[gi]),
            .ctrl_wr_in   (cwr[gi]),
            .cfg_in       (itp_cfg_type'(req_in.wdata[5:0])),                 // [R9] [R10]
            .latch_cnt_in (lcnt[gi]),
            .latch_sta_in (lsta[gi]),
            .data_wr_in   (dwr[gi]),
            .data_rd_in   (drd[gi]),
            .wdata_in     (req_in.wdata),
            .rdata_out    (rd[gi]),
            .out_out      (outs[gi])
         );
      end
   endgenerate
   assign counter0_out   = outs[0];
   assign pacer_sync_out = outs[2];                                           // [R5]
   // read select is remembered one cycle, counter data lands a cycle later
   always_comb begin
      rsel_nxt   = req_in.addr[2:1] - 2'b00;
      rsel_v_nxt = req_in.rd && (req_in.addr == ITP_OFS_CNT0 ||
                   req_in.addr == ITP_OFS_CNT1 || req_in.addr == ITP_OFS_CNT2);
      rdata_nxt  = 8'h00;
      if (rsel_v_r) begin
         rdata_nxt = rd[rsel_r];
      end
   end
   // conversion start pulse on rising pacer output
   assign adc_start_out = outs[2] && !p2_q_r_d;                               // [R5]
   // register divider, edge history and read data
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         div_r <= 2'b00; ext_q_r <= 1'b0; p2_q_r <= 1'b0; p2_q_r_d <= 1'b0;
         rsel_r <= 2'b00; rsel_v_r <= 1'b0; rdata_out <= 8'h00;
      end else begin
         div_r <= div_nxt; ext_q_r <= counter0_ext_clock; p2_q_r <= outs[1];
         p2_q_r_d <= outs[2]; rsel_r <= rsel_nxt; rsel_v_r <= rsel_v_nxt;
         rdata_out <= rsel_v_r ? rdata_nxt : rdata_out;
      end
   end
   // each pacer rise gives exactly one start pulse
   property p_adc_pulse;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      adc_start_out |=> !adc_start_out;
   endproperty
   a_adc_pulse: assert property (p_adc_pulse) else $error("start not a pulse"); // [R5]
   // internal tick every four system clocks
   property p_tick;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      tick_10mhz_out |=> !tick_10mhz_out [*3] ##1 tick_10mhz_out;
   endproperty
   a_tick: assert property (p_tick) else $error("tick period wrong"); // [R2]
   // a read-back with counts picks every counter selected
   property p_rb_latch;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      is_ctrl && is_rb && !req_in.wdata[ITP_RB_CNT_N] |->
         (lcnt == req_in.wdata[3:1]);
   endproperty
   a_rb_latch: assert property (p_rb_latch) else $error("read-back miss"); // [R11]
   // counter 0 holds its count while its gate is low in the modes with op_mode bit 0 clear
   property p_gate0;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      !counter0_gate_in && !g_cnt[0].u_cnt.load_r && !g_cnt[0].u_cnt.cfg_r.op_mode[0]
         |=> (g_cnt[0].u_cnt.cnt_r == $past(g_cnt[0].u_cnt.cnt_r));
   endproperty
   a_gate0: assert property (p_gate0) else $error("gate ignored"); // [R4]
endmodule

// ### tb/itp_host.sv
// itp_host: host bus model issuing byte writes and reads to the timer
// assumes strobes change on the falling edge and read data lands 3 edges late
`timescale 1ns/1ps
module itp_host (
   // clock and read data
   input  wire logic            clk_sys_in,
   input  wire logic [7:0]      rdata_in,
   // request to the timer
   output itp_pkg::itp_req_type req_out
);
   import itp_pkg::*;
   initial req_out = '0;
   // one-cycle write strobe; callers send the control word first
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_in);
      req_out = '{1'b1, 1'b0, a, d};
      @(negedge clk_sys_in);
      req_out = '0;
   endtask
   // one-cycle read strobe, data taken once it has settled
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys_in);
      req_out = '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk_sys_in);
      req_out = '0;
      repeat (3) @(negedge clk_sys_in);
      d = rdata_in;
   endtask
   // 16-bit count sent whole, low byte then high byte
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      wr(a, v[7:0]);
      wr(a, v[15:8]);
   endtask
endmodule

// ### tb/itp_top_bench.sv
// itp_top_bench: self-checking bench for the three-counter timer and pacer
// assumes the host model drives the register port; pins change on falling edges
`timescale 1ns/1ps
module itp_top_bench;
   import itp_pkg::*;
   logic        clk_sys_in = 1'b0;
   logic        rstn_in = 1'b0;
   itp_req_type req;
   logic [7:0]  rdata;
   logic [7:0]  b;
   logic        ext_clk = 1'b0;
   logic        gate0 = 1'b0;
   logic        src_ext = 1'b0;
   logic        pgate = 1'b1;
   logic        c0_out;
   logic        psync;
   logic        adc;
   logic        tick;
   int          n_errors = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          c0, n, hi, lo, na;
   logic [7:0]  t_ctl [4] = '{8'hb4, 8'hb6, 8'hbe, 8'hb5};
   logic [15:0] t_val [4] = '{16'h0003, 16'h0005, 16'h0004, 16'h0010};
   int          t_hi [4] = '{32, 48, 32, 144};
   int          t_lo [4] = '{16, 32, 32, 16};
   // 40 MHz system clock
   always #12.5 clk_sys_in = ~clk_sys_in;
   // design and host model
   itp_top u_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .req_in(req),
      .rdata_out(rdata), .counter0_ext_clock(ext_clk), .counter0_gate_in(gate0),
      .counter0_src_ext_in(src_ext), .counter0_out(c0_out), .pacer_gate_in(pgate),
      .pacer_sync_out(psync), .adc_start_out(adc), .tick_10mhz_out(tick));
   itp_host u_host (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .req_out(req));
   // verdict and end of run
   task automatic close_out();
      if (n_errors == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // byte and bit comparison
   task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   // cycle count comparison
   task automatic chk_n(input int g, input int e, input string m);
      tests_run++;
      if (g != e) begin
         n_errors++;
         $display("BAD %0t %s got %0d exp %0d", $time, m, g, e);
      end
   endtask
   // picks counter 0 output or pacer output
   function automatic logic pick(input int k);
      return (k == 0) ? c0_out : psync;
   endfunction
   // clocks until an output shows a level, bounded; counts start pulses
   task automatic wait_for(input int k, input logic v, output int cnt);
      cnt = 0;
      while (pick(k) !== v && cnt < 600) begin
         @(negedge clk_sys_in);
         cnt++;
         if (adc === 1'b1) na++;
      end
   endtask
   // hang guard: the whole run needs a few thousand clocks
   always @(negedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         close_out();
      end
   end
   // one pulse on the external count pin
   task automatic ext_pulse();
      @(negedge clk_sys_in);
      ext_clk = 1'b1;
      repeat (2) @(negedge clk_sys_in);
      ext_clk = 1'b0;
      repeat (2) @(negedge clk_sys_in);
   endtask
   // main sequence
   initial begin
      repeat (6) @(negedge clk_sys_in);
      rstn_in = 1'b1;
      na = 0;
      repeat (40) begin
         @(negedge clk_sys_in);
         if (tick === 1'b1) na++;
      end
      chk_n(na, 10, "tick rate");
      // counter 0 mode 0, gate low, latch before the gate rises, read while counting
      u_host.wr(ITP_OFS_CTRL, 8'h30);
      chk8({7'h00, c0_out}, 8'h00, "m0 low on mode");
      u_host.wr16(ITP_OFS_CNT0, 16'h0010);
      repeat (40) @(negedge clk_sys_in);
      chk8({7'h00, c0_out}, 8'h00, "gate low holds");
      u_host.wr(ITP_OFS_CTRL, 8'h00);
      @(negedge clk_sys_in);
      gate0 = 1'b1;
      c0 = cyc;
      u_host.rd(ITP_OFS_CNT0, b);
      chk8(b, 8'h10, "latched low");
      u_host.rd(ITP_OFS_CNT0, b);
      chk8(b, 8'h00, "latched high");
      wait_for(0, 1'b1, n);
      chk_n(int'(cyc - c0 >= 58 && cyc - c0 <= 74), 1, "m0 terminal");
      // read-back of counter 0 status
      u_host.wr(ITP_OFS_CTRL, 8'he2);
      u_host.rd(ITP_OFS_CNT0, b);
      chk8(b, 8'hb0, "status byte");
      // counter 0 as event counter on the external pin
      src_ext = 1'b1;
      u_host.wr(ITP_OFS_CTRL, 8'h30);
      chk8({7'h00, c0_out}, 8'h00, "m0 low again");
      u_host.wr16(ITP_OFS_CNT0, 16'h0003);
      repeat (40) @(negedge clk_sys_in);
      chk8({7'h00, c0_out}, 8'h00, "ticks ignored");
      repeat (3) ext_pulse();
      chk8({7'h00, c0_out}, 8'h00, "before last edge");
      ext_pulse();
      repeat (4) @(negedge clk_sys_in);
      chk8({7'h00, c0_out}, 8'h01, "event terminal");
      // counter 0 one-shot, software strobe and hardware strobe
      src_ext = 1'b0;
      gate0 = 1'b0;
      u_host.wr(ITP_OFS_CTRL, 8'h32);
      u_host.wr16(ITP_OFS_CNT0, 16'h0005);
      repeat (20) @(negedge clk_sys_in);
      chk8({7'h00, c0_out}, 8'h01, "m1 idle high");
      gate0 = 1'b1;
      wait_for(0, 1'b0, n);
      wait_for(0, 1'b1, lo);
      chk_n(lo, 20, "m1 pulse");
      u_host.wr(ITP_OFS_CTRL, 8'h38);
      u_host.wr16(ITP_OFS_CNT0, 16'h0003);
      wait_for(0, 1'b0, n);
      wait_for(0, 1'b1, lo);
      chk_n(lo, 4, "m4 strobe");
      gate0 = 1'b0;
      u_host.wr(ITP_OFS_CTRL, 8'h3a);
      u_host.wr16(ITP_OFS_CNT0, 16'h0003);
      repeat (20) @(negedge clk_sys_in);
      chk8({7'h00, c0_out}, 8'h01, "m5 waits for gate");
      gate0 = 1'b1;
      wait_for(0, 1'b0, n);
      chk_n(int'(n >= 13 && n <= 18), 1, "m5 delay");
      wait_for(0, 1'b1, lo);
      chk_n(lo, 4, "m5 strobe");
      // pacer: counter 1 divides by 4, counter 2 set per table entry
      u_host.wr(ITP_OFS_CTRL, 8'h74);
      u_host.wr16(ITP_OFS_CNT1, 16'h0004);
      for (int i = 0; i < 4; i++) begin
         u_host.wr(ITP_OFS_CTRL, t_ctl[i]);
         u_host.wr16(ITP_OFS_CNT2, t_val[i]);
         repeat (2) begin
            wait_for(1, 1'b1, n);
            wait_for(1, 1'b0, n);
         end
         wait_for(1, 1'b1, n);
         na = 0;
         wait_for(1, 1'b0, hi);
         wait_for(1, 1'b1, lo);
         chk_n(hi, t_hi[i], "pacer high");
         chk_n(lo, t_lo[i], "pacer low");
         chk_n(na, 1, "adc starts");
      end
      close_out();
   end
endmodule
